// ===== design/sab_aux_bit_bank.sv
// Functional notes
// - One select bit picks register arrays (0) or receiver-decoded bits (1).
// - Register bits are sent only while select is clear; select resets to zero.
// - Twelve 16-bit RW words hold 192 left channel status bits.
// - Twelve 16-bit RW words hold 192 right channel status bits.
// - Twelve 16-bit RW words hold 192 left user data bits.
// - Twelve 16-bit RW words hold 192 right user data bits.
// - Twelve 16-bit RW words hold 192 left validity bits.
// - Twelve 16-bit RW words hold 192 right validity bits.
// - Twelve 16-bit RW words hold 192 left parity bits.
// - Twelve 16-bit RW words hold 192 right parity bits.
// - All array words reset to zero; consecutive words sit one index apart.
// - Receiver source sends the per-channel bits decoded from the input stream.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

module sab_aux_bit_bank
   import sab_pkg::*;
(
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [APB_ADDR_W-1:0] paddr,
   input  wire logic [APB_DATA_W-1:0] pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [APB_DATA_W-1:0] prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Transmitter frame position and receiver bits
   input  wire logic [FRAME_W-1:0]    tx_frame_idx,
   input  wire logic [AUX_ARRAYS-1:0] rx_aux_bits,
   // Bits handed to the transmitter
   output logic      [AUX_ARRAYS-1:0] tx_aux_bits,
   output logic                       aux_origin_select
);

   logic                  origin_reg;
   logic                  origin_next;
   logic                  ack_reg;
   logic                  ack_next;
   logic                  err_reg;
   logic                  err_next;
   logic [AUX_WORD_W-1:0] rdata_reg;
   logic [AUX_WORD_W-1:0] rdata_next;
   logic [AUX_ARRAYS-1:0] rx_hold_reg;
   logic [AUX_ARRAYS-1:0] rx_hold_next;
   logic [AUX_ARRAYS-1:0] tx_bits_reg;
   logic [AUX_ARRAYS-1:0] tx_bits_next;

   logic [15:0]           reg_idx;
   logic [15:0]           arr_off;
   logic                  addr_aligned;
   logic                  hit_source;
   logic                  hit_array;
   logic                  hit_any;
   logic [AUX_ADDR_W-1:0] flat_addr;
   logic                  access_first;
   logic                  access_done;
   logic                  mem_wr_en;
   logic [AUX_WORD_W-1:0] mem_rdata;
   logic [AUX_ARRAYS-1:0] reg_bits;

   // Address decode: word index from the byte address
   assign reg_idx      = paddr[17:2];
   assign addr_aligned = (paddr[1:0] == 2'b00) && (paddr[31:18] == '0);
   assign arr_off      = reg_idx - IDX_CS_LEFT;
   assign hit_source   = addr_aligned && (reg_idx == IDX_SOURCE_SELECT);
   // Eight arrays of twelve words, spaced sixteen indexes apart
   assign hit_array    = addr_aligned && (reg_idx >= IDX_CS_LEFT)
                         && (arr_off <= IDX_ARRAY_SPAN)
                         && (arr_off[3:0] < WORD_LIMIT);
   assign hit_any      = hit_source || hit_array;
   assign flat_addr    = sab_flat_addr(arr_off[6:4], arr_off[3:0]);

   // Access phase takes two cycles: one to fetch, one to answer
   assign access_first = psel && penable && !ack_reg;
   assign access_done  = psel && penable && ack_reg;
   assign mem_wr_en    = access_done && pwrite && hit_array;

   // Word storage for all arrays
   sab_mem u_mem (
      .clock      (clock),
      .rst        (rst),
      .wr_en      (mem_wr_en),
      .wr_addr    (flat_addr),
      .wr_strb    (pstrb[1:0]),
      .wr_data    (pwdata[AUX_WORD_W-1:0]),
      .rd_addr    (flat_addr),
      .rd_data    (mem_rdata),
      .frame_idx  (tx_frame_idx),
      .frame_bits (reg_bits)
   );

   // Bus handshake, read data and the source select register
   always_comb
   begin
      ack_next    = access_first;
      err_next    = err_reg;
      rdata_next  = rdata_reg;
      origin_next = origin_reg;
      if (access_first)
      begin
         err_next   = !hit_any;
         rdata_next = AUX_WORD_RESET;
         if (hit_source)
         begin
            rdata_next[SRC_SEL_BIT] = origin_reg;
         end
         else if (hit_array)
         begin
            rdata_next = mem_rdata;
         end
      end
      if (access_done && pwrite && hit_source && pstrb[0])
      begin
         origin_next = pwdata[SRC_SEL_BIT];
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ack_reg    <= 1'b0;
         err_reg    <= 1'b0;
         rdata_reg  <= AUX_WORD_RESET;
         origin_reg <= SRC_REGISTERS;
      end
      else
      begin
         ack_reg    <= ack_next;
         err_reg    <= err_next;
         rdata_reg  <= rdata_next;
         origin_reg <= origin_next;
      end
   end

   assign pready  = ack_reg;
   assign pslverr = ack_reg && err_reg;
   assign prdata  = {{(APB_DATA_W-AUX_WORD_W){1'b0}}, rdata_reg};

   // Transmit bit selection, receiver bits delayed to line up with the bank
   always_comb
   begin
      rx_hold_next = rx_aux_bits;
      if (origin_reg == SRC_RECEIVER)
      begin
         tx_bits_next = rx_hold_reg;
      end
      else
      begin
         tx_bits_next = reg_bits;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rx_hold_reg <= '0;
         tx_bits_reg <= '0;
      end
      else
      begin
         rx_hold_reg <= rx_hold_next;
         tx_bits_reg <= tx_bits_next;
      end
   end

   assign tx_aux_bits       = tx_bits_reg;
   assign aux_origin_select = origin_reg;

endmodule

// ===== design/sab_pkg.sv
package sab_pkg;

   // Data path widths and array geometry
   localparam int unsigned AUX_WORD_W  = 16;
   localparam int unsigned AUX_WORDS   = 12;
   localparam int unsigned AUX_ARRAYS  = 8;
   localparam int unsigned AUX_DEPTH   = 96;
   localparam int unsigned AUX_ADDR_W  = 7;
   localparam int unsigned AUX_FRAMES  = 192;
   localparam int unsigned FRAME_W     = 8;
   localparam int unsigned APB_DATA_W  = 32;
   localparam int unsigned APB_ADDR_W  = 32;

   // Register indexes; byte address is four times the index
   localparam logic [15:0] IDX_SOURCE_SELECT = 16'hf69f;
   localparam logic [15:0] IDX_CS_LEFT       = 16'hf6a0;
   localparam logic [15:0] IDX_CS_RIGHT      = 16'hf6b0;
   localparam logic [15:0] IDX_USER_LEFT     = 16'hf6c0;
   localparam logic [15:0] IDX_USER_RIGHT    = 16'hf6d0;
   localparam logic [15:0] IDX_VALID_LEFT    = 16'hf6e0;
   localparam logic [15:0] IDX_VALID_RIGHT   = 16'hf6f0;
   localparam logic [15:0] IDX_PARITY_LEFT   = 16'hf700;
   localparam logic [15:0] IDX_PARITY_RIGHT  = 16'hf710;
   localparam logic [15:0] IDX_ARRAY_SPAN    = 16'h007f;

   // Field positions and reset values
   localparam int unsigned SRC_SEL_BIT    = 0;
   localparam logic        SRC_REGISTERS  = 1'b0;
   localparam logic        SRC_RECEIVER   = 1'b1;
   localparam logic [15:0] AUX_WORD_RESET = 16'h0000;
   localparam logic [3:0]  WORD_LIMIT     = 4'hc;

   // Array order inside the bank and in the per-frame bit vectors
   localparam int unsigned ARR_CS_LEFT      = 0;
   localparam int unsigned ARR_CS_RIGHT     = 1;
   localparam int unsigned ARR_USER_LEFT    = 2;
   localparam int unsigned ARR_USER_RIGHT   = 3;
   localparam int unsigned ARR_VALID_LEFT   = 4;
   localparam int unsigned ARR_VALID_RIGHT  = 5;
   localparam int unsigned ARR_PARITY_LEFT  = 6;
   localparam int unsigned ARR_PARITY_RIGHT = 7;

   // Flat storage address of one word of one array
   function automatic logic [AUX_ADDR_W-1:0] sab_flat_addr(input logic [2:0] arr,
                                                           input logic [3:0] word);
      logic [AUX_ADDR_W-1:0] base;
      base = 7'(arr) * 7'(AUX_WORDS);
      return base + 7'(word);
   endfunction

endpackage

// ===== design/sab_mem.sv
`timescale 1ns/1ps

module sab_mem
   import sab_pkg::*;
(
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst,
   // Bus write port
   input  wire logic                  wr_en,
   input  wire logic [AUX_ADDR_W-1:0] wr_addr,
   input  wire logic [1:0]            wr_strb,
   input  wire logic [AUX_WORD_W-1:0] wr_data,
   // Bus read port
   input  wire logic [AUX_ADDR_W-1:0] rd_addr,
   output logic      [AUX_WORD_W-1:0] rd_data,
   // Frame bit read port
   input  wire logic [FRAME_W-1:0]    frame_idx,
   output logic      [AUX_ARRAYS-1:0] frame_bits
);

   logic [AUX_WORD_W-1:0] mem_reg [AUX_DEPTH];
   logic [AUX_WORD_W-1:0] mem_next [AUX_DEPTH];
   logic [AUX_WORD_W-1:0] rd_data_next;
   logic [AUX_ARRAYS-1:0] bits_next;
   logic                  frame_ok;

   assign frame_ok = (frame_idx < 8'(AUX_FRAMES));

   // Byte-lane write into the bank
   always_comb
   begin
      for (int i = 0; i < AUX_DEPTH; i++)
      begin
         mem_next[i] = mem_reg[i];
      end
      if (wr_en && (wr_addr < 7'(AUX_DEPTH)))
      begin
         if (wr_strb[0])
         begin
            mem_next[wr_addr][7:0] = wr_data[7:0];
         end
         if (wr_strb[1])
         begin
            mem_next[wr_addr][15:8] = wr_data[15:8];
         end
      end
      rd_data_next = (rd_addr < 7'(AUX_DEPTH)) ? mem_reg[rd_addr] : AUX_WORD_RESET;
   end

   // One bit per array: word frame/16, bit frame%16, LSB first
   genvar a;
   generate
      for (a = 0; a < AUX_ARRAYS; a++)
      begin : g_bit
         logic [AUX_WORD_W-1:0] word_sel;
         assign word_sel     = mem_reg[sab_flat_addr(3'(a), frame_idx[7:4])];
         assign bits_next[a] = frame_ok ? word_sel[frame_idx[3:0]] : 1'b0;
      end
   endgenerate

   // Storage and read registers, all words clear at reset
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         for (int i = 0; i < AUX_DEPTH; i++)
         begin
            mem_reg[i] <= AUX_WORD_RESET;
         end
         rd_data    <= AUX_WORD_RESET;
         frame_bits <= '0;
      end
      else
      begin
         for (int i = 0; i < AUX_DEPTH; i++)
         begin
            mem_reg[i] <= mem_next[i];
         end
         rd_data    <= rd_data_next;
         frame_bits <= bits_next;
      end
   end

endmodule

// ===== dv/sab_link_model.sv
`timescale 1ns/1ps
// Transmitter side: frame position and decoded receiver bits
module sab_link_model
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Frame position and receiver bits
   output logic      [7:0] frame_idx,
   output logic      [7:0] rx_bits
);
   // Position wraps after the last frame of a block
   always_ff @(posedge clock)
   begin
      frame_idx <= (rst || frame_idx == 8'hbf) ? 8'h0 : frame_idx + 8'h1;
   end
   // Bits change every frame so a stale copy shows
   assign rx_bits = frame_idx ^ 8'h5a;
endmodule

// ===== dv/sab_aux_bit_bank_monitor.sv
`timescale 1ns/1ps
// Bus timing and transmit path checks
module sab_aux_bit_bank_monitor
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Transmit path
   input wire logic [7:0]  rx_aux_bits,
   input wire logic [7:0]  tx_aux_bits,
   input wire logic        aux_origin_select
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Bus answer timing and flags
   chk_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_misaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access accepted");
   chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read bits set");
   // Receiver bits pass through two stages
   chk_rx_path: assert property (aux_origin_select && $past(aux_origin_select)
      && $past(aux_origin_select, 2) |-> tx_aux_bits == $past(rx_aux_bits, 2))
      else $error("receiver bits not forwarded");
   chk_reset_state: assert property (disable iff (1'b0) rst |=> !pready
      && tx_aux_bits == 8'h0 && !aux_origin_select)
      else $error("outputs not cleared by reset");
   cov_err: cover property (pslverr);
   cov_rx: cover property (aux_origin_select && tx_aux_bits != 8'h0);
   cov_reg: cover property (!aux_origin_select && tx_aux_bits != 8'h0);
endmodule
bind sab_aux_bit_bank sab_aux_bit_bank_monitor mon_u (.clock(clock), .rst(rst), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rx_aux_bits(rx_aux_bits), .tx_aux_bits(tx_aux_bits),
   .aux_origin_select(aux_origin_select));

// ===== dv/sab_aux_bit_bank_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module sab_aux_bit_bank_bench
   import sab_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  idx;
   logic [7:0]  rx;
   logic [7:0]  txb;
   logic        sel;
   logic [31:0] rd;
   logic        er;
   logic [15:0] sh [8][12];
   int          checks = 0;
   int          miscompares = 0;
   sab_aux_bit_bank dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_frame_idx(idx), .rx_aux_bits(rx),
      .tx_aux_bits(txb), .aux_origin_select(sel));
   sab_link_model lnk_u (.clock(clock), .rst(rst), .frame_idx(idx), .rx_bits(rx));
   // Free running clock
   initial
   begin
      forever #25 clock = ~clock;
   end
   task automatic end_of_test();
      if (miscompares == 0 && checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] wa(input int a, input int w);
      return {14'h0, IDX_CS_LEFT + 16'(a * 16 + w), 2'h0};
   endfunction
   // One transfer; request held until the edge that samples ready
   task automatic apb(input logic wr, input logic [31:0] ad, input logic [15:0] wd,
                      input logic [3:0] st);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= {16'h0, wd};
      pstrb <= st;
      @(posedge clock);
      penable <= 1'b1;
      // Ready, read data and error are all taken at the rising edge that samples ready
      do
      begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (pready !== 1'b1)
      begin
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic t_words();
      for (int a = 0; a < 8; a++)
      begin
         for (int w = 0; w < 12; w++)
         begin
            apb(1'b0, wa(a, w), 16'h0, 4'hf);
            `CHK("reset word", 32'h0, rd)
            sh[a][w] = {4'(a), 4'(w), 8'h3c ^ 8'(a * 12 + w)};
            apb(1'b1, wa(a, w), sh[a][w], 4'hf);
         end
      end
      for (int a = 0; a < 8; a++)
      begin
         for (int w = 0; w < 12; w++)
         begin
            apb(1'b0, wa(a, w), 16'h0, 4'hf);
            `CHK("word", {16'h0, sh[a][w]}, rd)
            `CHK("word error", 1'b0, er)
         end
      end
   endtask
   task automatic t_errs();
      apb(1'b0, wa(0, 12), 16'h0, 4'hf);
      `CHK("gap error", 1'b1, er)
      `CHK("gap data", 32'h0, rd)
      apb(1'b1, wa(0, 0) | 32'h2, 16'hffff, 4'hf);
      `CHK("misaligned error", 1'b1, er)
      apb(1'b1, wa(7, 11), 16'h55aa, 4'h2);
      sh[7][11] = {8'h55, sh[7][11][7:0]};
      apb(1'b0, wa(7, 11), 16'h0, 4'hf);
      `CHK("byte lane", {16'h0, sh[7][11]}, rd)
   endtask
   // Transmitted bits follow position and source two cycles on
   task automatic t_stream(input logic src);
      logic [7:0] ih [$];
      logic [7:0] rh [$];
      logic [7:0] ex;
      apb(1'b1, {14'h0, IDX_SOURCE_SELECT, 2'h0}, {15'h0, src}, 4'hf);
      apb(1'b0, {14'h0, IDX_SOURCE_SELECT, 2'h0}, 16'h0, 4'hf);
      `CHK("select readback", {31'h0, src}, rd)
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (4) @(negedge clock);
      `CHK("select", src, sel)
      for (int k = 0; k < 400; k++)
      begin
         @(negedge clock);
         ih.push_back(idx);
         rh.push_back(rx);
         if (k >= 2)
         begin
            for (int a = 0; a < 8; a++) ex[a] = sh[a][ih[0] / 16][ih[0] % 16];
            ex = src ? rh[0] : ex;
            `CHK("tx bits", ex, txb)
            void'(ih.pop_front());
            void'(rh.pop_front());
         end
      end
      // Return on a rising edge so the next request starts right after it
      @(posedge clock);
   endtask
   // Reset in mid-run clears the last array word written; the select is already clear before it
   task automatic t_reset();
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      `CHK("select after reset", 1'b0, sel)
      apb(1'b0, wa(7, 11), 16'h0, 4'hf);
      `CHK("word after reset", 32'h0, rd)
   endtask
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      `CHK("select at reset", 1'b0, sel)
      t_words();
      t_errs();
      t_stream(1'b1);
      t_stream(1'b0);
      t_reset();
      end_of_test();
   end
endmodule
